// *** nci_cmd_interp.sv ***
/*
 * command interpreter of a token-passing network node: the host writes a
 * parameter and a command code over a byte register port; the block keeps
 * the line, filter, retry and timer settings and drives them as levels.
 * assumes synchronous host strobes on mclk and logic inputs on mclk.
 */
`timescale 1ns/10ps
module nci_cmd_interp #(
  parameter bit EVAL_BUILD = 1'b0,
  parameter bit HAS_PROMISC = 1'b1,
  parameter bit HAS_NODE_LIST = 1'b1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // protocol engine status
  input wire logic excess_event,
  input wire logic [255:0] node_map,
  // settings
  output logic [3:0] line_rate,
  output logic [7:0] own_node_id,
  output logic link_enable,
  output logic protocol_reset,
  output logic transfer_cancel,
  output logic [3:0] retry_exp,
  output logic abort_on_excess,
  output logic tx_abort,
  output logic promisc_enable,
  output logic bcast_enable,
  output logic [7:0] msg_filter,
  output logic queue_clear,
  output logic test_bad_crc,
  output logic test_ignore_token,
  output logic token_repeat,
  output logic [15:0] tlt_value,
  output logic [15:0] tip_value,
  output logic [15:0] tac_value,
  output logic [15:0] trp_value,
  output logic irq_suppress
);

  nci_exec_if ex();

  nci_node_walker #(
    .MAX_REPORTS(nci_pkg::NODE_REPORT_MAX)
  ) u_walker (
    .mclk(mclk),
    .resetn(resetn),
    .node_map(node_map),
    .ex(ex)
  );

  // *****************************************
  // state
  // *****************************************
  nci_pkg::nci_state_e st_ff, nxt_st;
  logic [7:0] par_ff, nxt_par;
  logic [7:0] code_ff, nxt_code;
  logic [9:0] wait_ff, nxt_wait;
  logic [3:0] rate_ff, nxt_rate;
  logic [7:0] nid_ff, nxt_nid;
  logic en_ff, nxt_en;
  logic preset_ff, nxt_preset;
  logic cancel_ff, nxt_cancel;
  logic [3:0] rexp_ff, nxt_rexp;
  logic abort_ff, nxt_abort;
  logic txab_ff, nxt_txab;
  logic prom_ff, nxt_prom;
  logic bc_ff, nxt_bc;
  logic [7:0] filt_ff, nxt_filt;
  logic qclr_ff, nxt_qclr;
  logic crc_ff, nxt_crc;
  logic itok_ff, nxt_itok;
  logic trep_ff, nxt_trep;
  logic [15:0] tlt_ff, nxt_tlt;
  logic [15:0] tip_ff, nxt_tip;
  logic [15:0] tac_ff, nxt_tac;
  logic [15:0] trp_ff, nxt_trp;
  logic [7:0] sys_ff, nxt_sys;
  logic [7:0] rpt_ff, nxt_rpt;
  logic irqm_ff, nxt_irqm;
  logic [7:0] rdata_ff, nxt_rdata;
  logic start_walk;

  wire logic busy = (st_ff != nci_pkg::NCI_IDLE);
  wire logic cmd_wr = reg_wr && reg_addr == nci_pkg::REG_CMD && !busy;
  wire logic [9:0] wait_last = (code_ff == nci_pkg::CMD_LINK_RESET) ?
    10'(nci_pkg::LINK_RESET_CYCLES - 1) : 10'(nci_pkg::EXEC_CYCLES - 1);

  assign ex.start = start_walk;
  assign ex.first_id = par_ff;

  // *****************************************
  // command decode and execution
  // *****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_par = par_ff;
    nxt_code = code_ff;
    nxt_wait = wait_ff;
    nxt_rate = rate_ff;
    nxt_nid = nid_ff;
    nxt_en = en_ff;
    nxt_preset = 1'b0;
    nxt_cancel = 1'b0;
    nxt_rexp = rexp_ff;
    nxt_abort = abort_ff;
    nxt_txab = 1'b0;
    nxt_prom = prom_ff;
    nxt_bc = bc_ff;
    nxt_filt = filt_ff;
    nxt_qclr = 1'b0;
    nxt_crc = crc_ff;
    nxt_itok = itok_ff;
    nxt_trep = trep_ff;
    nxt_tlt = tlt_ff;
    nxt_tip = tip_ff;
    nxt_tac = tac_ff;
    nxt_trp = trp_ff;
    nxt_sys = sys_ff;
    nxt_rpt = rpt_ff;
    nxt_irqm = irqm_ff;
    start_walk = 1'b0;
    if (reg_wr && reg_addr == nci_pkg::REG_PARAM) begin
      nxt_irqm = 1'b1;
      if (!busy) begin
        nxt_par = reg_wdata;
      end
    end
    if (excess_event) begin
      nxt_sys[nci_pkg::SYS_EXCESS_BIT] = 1'b1;
      nxt_txab = abort_ff;
    end
    if (reg_rd && reg_addr == nci_pkg::REG_SYS_STATUS && !excess_event) begin
      nxt_sys = 8'h00;
    end
    if (ex.rpt_valid) begin
      nxt_rpt = ex.rpt_id;
    end
    unique case (st_ff)
      nci_pkg::NCI_IDLE: begin
        if (cmd_wr) begin
          nxt_code = reg_wdata;
          nxt_irqm = 1'b0;
          nxt_st = nci_pkg::NCI_EXEC;
          nxt_wait = 10'h000;
        end
      end
      nci_pkg::NCI_EXEC: begin
        nxt_wait = wait_ff + 10'h001;
        if (wait_ff == 10'h000) begin
          unique case (code_ff)
            nci_pkg::CMD_SET_RATE: begin
              if (par_ff[7:4] == 4'h0 && par_ff[3:0] <= nci_pkg::RATE_MAX) begin
                nxt_rate = par_ff[3:0];
                nxt_preset = 1'b1;
              end
            end
            nci_pkg::CMD_SET_OWN_ID: begin
              if (!EVAL_BUILD && par_ff != 8'h00) begin
                nxt_nid = par_ff;
              end
            end
            nci_pkg::CMD_READ_SETTING: begin
              unique case (par_ff)
                nci_pkg::SUB_RETRY: nxt_par = {3'h0, abort_ff, rexp_ff};
                nci_pkg::SUB_RATE: nxt_par = {4'h0, rate_ff};
                nci_pkg::SUB_NODE_ID: nxt_par = nid_ff;
                default: nxt_par = 8'h00;
              endcase
            end
            nci_pkg::CMD_LINK_DISABLE: begin
              nxt_en = 1'b0;
              nxt_cancel = 1'b1;
            end
            nci_pkg::CMD_LINK_ENABLE: nxt_en = 1'b1;
            nci_pkg::CMD_LINK_RESET: begin
              nxt_en = 1'b0;
              nxt_preset = 1'b1;
              nxt_cancel = 1'b1;
              if (!EVAL_BUILD) begin
                nxt_nid = 8'h00;
              end
              nxt_rexp = nci_pkg::RETRY_EXP_DEF;
              nxt_abort = 1'b0;
              nxt_prom = 1'b0;
              nxt_bc = 1'b0;
              nxt_filt = nci_pkg::FILTER_DEF;
              nxt_crc = 1'b0;
              nxt_itok = 1'b0;
              nxt_trep = 1'b0;
              nxt_tlt = nci_pkg::TLT_DEF;
              nxt_tip = nci_pkg::TIP_DEF;
              nxt_tac = nci_pkg::TAC_DEF;
              nxt_trp = nci_pkg::TRP_DEF;
            end
            nci_pkg::CMD_SET_RETRY: begin
              nxt_rexp = par_ff[3:0];
              nxt_abort = par_ff[nci_pkg::RETRY_ABORT_BIT];
            end
            nci_pkg::CMD_PROMISC_ON: nxt_prom = HAS_PROMISC;
            nci_pkg::CMD_PROMISC_OFF: nxt_prom = 1'b0;
            nci_pkg::CMD_BCAST_ON: nxt_bc = 1'b1;
            nci_pkg::CMD_BCAST_OFF: nxt_bc = 1'b0;
            nci_pkg::CMD_MSG_FILTER: nxt_filt = par_ff;
            nci_pkg::CMD_QUEUE_CLEAR: nxt_qclr = 1'b1;
            nci_pkg::CMD_TEST_FEATURE: begin
              if (par_ff == nci_pkg::TEST_BAD_CRC) begin
                nxt_crc = 1'b1;
              end
              if (par_ff == nci_pkg::TEST_IGNORE_TOKEN) begin
                nxt_itok = 1'b1;
              end
            end
            nci_pkg::CMD_TOKEN_REPEAT: nxt_trep = par_ff[0];
            nci_pkg::CMD_NODE_REPORT: begin
              if (HAS_NODE_LIST && par_ff != 8'h00 && par_ff != 8'hff) begin
                start_walk = 1'b1;
                nxt_st = nci_pkg::NCI_WALK;
              end
            end
            nci_pkg::CMD_TLT_LO: nxt_tlt[7:0] = par_ff;
            nci_pkg::CMD_TLT_HI: nxt_tlt[15:8] = par_ff;
            nci_pkg::CMD_TIP_LO: nxt_tip[7:0] = par_ff;
            nci_pkg::CMD_TIP_HI: nxt_tip[15:8] = par_ff;
            nci_pkg::CMD_TAC_LO: nxt_tac[7:0] = par_ff;
            nci_pkg::CMD_TAC_HI: nxt_tac[15:8] = par_ff;
            nci_pkg::CMD_TRP_LO: nxt_trp[7:0] = par_ff;
            nci_pkg::CMD_TRP_HI: nxt_trp[15:8] = par_ff;
            default: ;
          endcase
        end else if (wait_ff >= wait_last) begin
          nxt_st = nci_pkg::NCI_IDLE;
        end
      end
      nci_pkg::NCI_WALK: begin
        if (!ex.busy && !start_walk) begin
          nxt_st = nci_pkg::NCI_IDLE;
        end
      end
      default: nxt_st = nci_pkg::NCI_IDLE;
    endcase
  end

  // *****************************************
  // read data, one cycle after the strobe
  // *****************************************
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        nci_pkg::REG_PARAM: nxt_rdata = par_ff;
        nci_pkg::REG_CMD: nxt_rdata = busy ? nci_pkg::CMD_BUSY : code_ff;
        nci_pkg::REG_SYS_STATUS: nxt_rdata = sys_ff;
        nci_pkg::REG_NODE_REPORT: nxt_rdata = rpt_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= nci_pkg::NCI_IDLE;
      par_ff <= 8'h00;
      code_ff <= 8'h00;
      wait_ff <= 10'h000;
      rate_ff <= 4'h0;
      nid_ff <= EVAL_BUILD ? nci_pkg::EVAL_NODE_ID : 8'h00;
      en_ff <= 1'b0;
      preset_ff <= 1'b0;
      cancel_ff <= 1'b0;
      rexp_ff <= nci_pkg::RETRY_EXP_DEF;
      abort_ff <= 1'b0;
      txab_ff <= 1'b0;
      prom_ff <= 1'b0;
      bc_ff <= 1'b0;
      filt_ff <= nci_pkg::FILTER_DEF;
      qclr_ff <= 1'b0;
      crc_ff <= 1'b0;
      itok_ff <= 1'b0;
      trep_ff <= 1'b0;
      tlt_ff <= nci_pkg::TLT_DEF;
      tip_ff <= nci_pkg::TIP_DEF;
      tac_ff <= nci_pkg::TAC_DEF;
      trp_ff <= nci_pkg::TRP_DEF;
      sys_ff <= 8'h00;
      rpt_ff <= 8'h00;
      irqm_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      par_ff <= nxt_par;
      code_ff <= nxt_code;
      wait_ff <= nxt_wait;
      rate_ff <= nxt_rate;
      nid_ff <= EVAL_BUILD ? nci_pkg::EVAL_NODE_ID : nxt_nid;
      en_ff <= nxt_en;
      preset_ff <= nxt_preset;
      cancel_ff <= nxt_cancel;
      rexp_ff <= nxt_rexp;
      abort_ff <= nxt_abort;
      txab_ff <= nxt_txab;
      prom_ff <= nxt_prom;
      bc_ff <= nxt_bc;
      filt_ff <= nxt_filt;
      qclr_ff <= nxt_qclr;
      crc_ff <= nxt_crc;
      itok_ff <= nxt_itok;
      trep_ff <= nxt_trep;
      tlt_ff <= nxt_tlt;
      tip_ff <= nxt_tip;
      tac_ff <= nxt_tac;
      trp_ff <= nxt_trp;
      sys_ff <= nxt_sys;
      rpt_ff <= nxt_rpt;
      irqm_ff <= nxt_irqm;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign line_rate = rate_ff;
  assign own_node_id = nid_ff;
  assign link_enable = en_ff;
  assign protocol_reset = preset_ff;
  assign transfer_cancel = cancel_ff;
  assign retry_exp = rexp_ff;
  assign abort_on_excess = abort_ff;
  assign tx_abort = txab_ff;
  assign promisc_enable = prom_ff;
  assign bcast_enable = bc_ff;
  assign msg_filter = filt_ff;
  assign queue_clear = qclr_ff;
  assign test_bad_crc = crc_ff;
  assign test_ignore_token = itok_ff;
  assign token_repeat = trep_ff;
  assign tlt_value = tlt_ff;
  assign tip_value = tip_ff;
  assign tac_value = tac_ff;
  assign trp_value = trp_ff;
  assign irq_suppress = irqm_ff;

  // *****************************************
  // checks
  // *****************************************
  sequence s_cmd(logic [7:0] c);
    cmd_wr && reg_wdata == c;
  endsequence

  chk_rate_reset: assert property (@(posedge mclk) disable iff (!resetn)
    s_cmd(nci_pkg::CMD_SET_RATE) ##1 (par_ff <= 8'(nci_pkg::RATE_MAX)) |=> protocol_reset)
    else $error("rate change did not reset protocol");
  chk_eval_id: assert property (@(posedge mclk) disable iff (!resetn)
    EVAL_BUILD |-> own_node_id == nci_pkg::EVAL_NODE_ID)
    else $error("evaluation node id changed");
  chk_link_off: assert property (@(posedge mclk) disable iff (!resetn)
    s_cmd(nci_pkg::CMD_LINK_DISABLE) |=> ##1 !link_enable && transfer_cancel)
    else $error("link disable failed");
  chk_link_on: assert property (@(posedge mclk) disable iff (!resetn)
    s_cmd(nci_pkg::CMD_LINK_ENABLE) |=> ##1 link_enable)
    else $error("link enable failed");
  chk_reset_defaults: assert property (@(posedge mclk) disable iff (!resetn)
    s_cmd(nci_pkg::CMD_LINK_RESET) |=> ##1 (msg_filter == nci_pkg::FILTER_DEF
      && tlt_value == nci_pkg::TLT_DEF && !link_enable && $stable(line_rate)))
    else $error("link reset did not restore defaults");
  chk_abort_follow: assert property (@(posedge mclk) disable iff (!resetn)
    excess_event |=> tx_abort == $past(abort_ff) && sys_ff[nci_pkg::SYS_EXCESS_BIT])
    else $error("excess refusal handling wrong");
  chk_busy_read: assert property (@(posedge mclk) disable iff (!resetn)
    reg_rd && reg_addr == nci_pkg::REG_CMD && busy |=> reg_rdata == nci_pkg::CMD_BUSY)
    else $error("command register not busy code");
  chk_cmd_done: assert property (@(posedge mclk) disable iff (!resetn)
    s_cmd(nci_pkg::CMD_BCAST_ON) |=> busy [*2] ##1 !busy ##0 code_ff == nci_pkg::CMD_BCAST_ON)
    else $error("command did not complete");
  chk_par_locked: assert property (@(posedge mclk) disable iff (!resetn)
    busy && st_ff == nci_pkg::NCI_WALK |=> $stable(par_ff))
    else $error("parameter changed while busy");

endmodule

// *** nci_engine_model.sv ***
/*
 * protocol engine stand-in: raises the excess-refusal event and holds a
 * detected-node list.
 * assumes the bench requests an event with a one-cycle fire pulse on mclk.
 */
`timescale 1ns/10ps
module nci_engine_model (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // bench request
  input wire logic fire,
  // engine status
  output logic excess_event,
  output logic [255:0] node_map
);
  // *****************************************
  // event and node list
  // *****************************************
  // nodes 3 and 5 detected
  assign node_map = 256'h28;
  // event launched just after an edge, one cycle long
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      excess_event <= 1'b0;
    end else begin
      excess_event <= fire;
    end
  end
endmodule

// *** nci_exec_if.sv ***
/*
 * interface between the command decoder and its node list walker.
 * assumes both ends on mclk.
 */
`timescale 1ns/10ps
interface nci_exec_if;
  logic start;
  logic [7:0] first_id;
  logic busy;
  logic rpt_valid;
  logic [7:0] rpt_id;
  modport ctrl (output start, output first_id, input busy, input rpt_valid, input rpt_id);
  modport walker (input start, input first_id, output busy, output rpt_valid, output rpt_id);
endinterface

// *** nci_node_walker.sv ***
/*
 * walks the detected-node bitmap upward from a start id, reporting each
 * set id, stopping after a fixed count or at the end of the list.
 * assumes node_map is a level from logic in the same clock domain.
 */
`timescale 1ns/10ps
module nci_node_walker #(
  parameter int MAX_REPORTS = nci_pkg::NODE_REPORT_MAX
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // detected-node list
  input wire logic [255:0] node_map,
  // decoder side
  nci_exec_if.walker ex
);

  logic [7:0] id_ff, nxt_id;
  logic [3:0] cnt_ff, nxt_cnt;
  logic busy_ff, nxt_busy;
  logic vld_ff, nxt_vld;
  // id of the last hit, held apart from the scan pointer that moves on
  logic [7:0] rid_ff, nxt_rid;

  // *****************************************
  // walk one id per cycle
  // *****************************************
  always_comb begin
    nxt_id = id_ff;
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_vld = 1'b0;
    nxt_rid = rid_ff;
    if (ex.start) begin
      nxt_id = ex.first_id;
      nxt_cnt = 4'h0;
      nxt_busy = 1'b1;
    end else if (busy_ff) begin
      if (node_map[id_ff]) begin
        nxt_vld = 1'b1;
        nxt_rid = id_ff;
        nxt_cnt = cnt_ff + 4'h1;
      end
      if ((node_map[id_ff] && (cnt_ff + 4'h1 == 4'(MAX_REPORTS))) || id_ff == 8'hff) begin
        nxt_busy = 1'b0;
      end else begin
        nxt_id = id_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      id_ff <= 8'h00;
      cnt_ff <= 4'h0;
      busy_ff <= 1'b0;
      vld_ff <= 1'b0;
      rid_ff <= 8'h00;
    end else begin
      id_ff <= nxt_id;
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      vld_ff <= nxt_vld;
      rid_ff <= nxt_rid;
    end
  end

  assign ex.busy = busy_ff;
  assign ex.rpt_valid = vld_ff;
  assign ex.rpt_id = rid_ff;

  chk_walk_bounded: assert property (@(posedge mclk) disable iff (!resetn)
    ex.start |=> busy_ff [*1] ##[0:300] !busy_ff)
    else $error("node walk did not finish in time");

endmodule

// *** nci_pkg.sv ***
/*
 * package of the node command interpreter: register offsets, command codes,
 * setting defaults and timing constants.
 * assumes a single 25 MHz controller clock domain.
 */
package nci_pkg;

  // *****************************************
  // register offsets (4-bit address)
  // *****************************************
  localparam logic [3:0] REG_PARAM = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h1;
  localparam logic [3:0] REG_SYS_STATUS = 4'h8;
  localparam logic [3:0] REG_NODE_REPORT = 4'h9;

  // *****************************************
  // command codes
  // *****************************************
  localparam logic [7:0] CMD_SET_OWN_ID = 8'h01;
  localparam logic [7:0] CMD_SET_RETRY = 8'h07;
  localparam logic [7:0] CMD_SET_RATE = 8'h08;
  localparam logic [7:0] CMD_MSG_FILTER = 8'h0c;
  localparam logic [7:0] CMD_TLT_LO = 8'h10;
  localparam logic [7:0] CMD_TLT_HI = 8'h11;
  localparam logic [7:0] CMD_TIP_LO = 8'h12;
  localparam logic [7:0] CMD_TIP_HI = 8'h13;
  localparam logic [7:0] CMD_TAC_LO = 8'h14;
  localparam logic [7:0] CMD_TAC_HI = 8'h15;
  localparam logic [7:0] CMD_TRP_LO = 8'h16;
  localparam logic [7:0] CMD_TRP_HI = 8'h17;
  localparam logic [7:0] CMD_READ_SETTING = 8'h29;
  localparam logic [7:0] CMD_LINK_DISABLE = 8'h37;
  localparam logic [7:0] CMD_LINK_ENABLE = 8'h38;
  localparam logic [7:0] CMD_BCAST_ON = 8'h42;
  localparam logic [7:0] CMD_BCAST_OFF = 8'h43;
  localparam logic [7:0] CMD_LINK_RESET = 8'h44;
  localparam logic [7:0] CMD_QUEUE_CLEAR = 8'h45;
  localparam logic [7:0] CMD_TEST_FEATURE = 8'h46;
  localparam logic [7:0] CMD_TOKEN_REPEAT = 8'h48;
  localparam logic [7:0] CMD_NODE_REPORT = 8'h4d;
  localparam logic [7:0] CMD_PROMISC_ON = 8'h4e;
  localparam logic [7:0] CMD_PROMISC_OFF = 8'h4f;
  localparam logic [7:0] CMD_BUSY = 8'hff;

  // *****************************************
  // read_setting subcommands
  // *****************************************
  localparam logic [7:0] SUB_RETRY = 8'h07;
  localparam logic [7:0] SUB_RATE = 8'h08;
  localparam logic [7:0] SUB_NODE_ID = 8'h01;

  // *****************************************
  // defaults and field positions
  // *****************************************
  localparam logic [3:0] RATE_MAX = 4'h9;
  localparam logic [7:0] EVAL_NODE_ID = 8'h0a;
  localparam logic [3:0] RETRY_EXP_DEF = 4'h7;
  localparam int RETRY_ABORT_BIT = 4;
  localparam logic [7:0] FILTER_DEF = 8'h3f;
  localparam logic [15:0] TLT_DEF = 16'h0401;
  localparam logic [15:0] TIP_DEF = 16'h02da;
  localparam logic [15:0] TAC_DEF = 16'h01a9;
  localparam logic [15:0] TRP_DEF = 16'h017f;
  localparam logic [7:0] TEST_BAD_CRC = 8'h01;
  localparam logic [7:0] TEST_IGNORE_TOKEN = 8'h02;
  localparam int NODE_REPORT_MAX = 8;
  localparam int SYS_EXCESS_BIT = 0;

  // *****************************************
  // timing
  // *****************************************
  localparam int CLK_MHZ = 25;
  localparam int EXEC_CYCLES = 2;
  localparam int LINK_RESET_NS = 20000;
  localparam int LINK_RESET_CYCLES = (LINK_RESET_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    NCI_IDLE = 2'b00,
    NCI_EXEC = 2'b01,
    NCI_WALK = 2'b11
  } nci_state_e;

endpackage

// *** tb.sv ***
/*
 * self-checking bench of the node command interpreter.
 * assumes the default build options and a 25 MHz mclk.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb;
  // *****************************************
  // signals
  // *****************************************
  logic mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fire = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_v, own_node_id, msg_filter;
  logic excess_event, link_enable, protocol_reset, transfer_cancel, abort_on_excess;
  logic tx_abort, promisc_enable, bcast_enable, queue_clear, test_bad_crc;
  logic test_ignore_token, token_repeat, irq_suppress;
  logic [255:0] node_map;
  logic [3:0] line_rate, retry_exp;
  logic [15:0] tlt_value, tip_value, tac_value, trp_value;
  int errors = 0, checks_done = 0, cyc = 0;
  int qc_n = 0, pr_n = 0, tc_n = 0;
  // count the one-cycle pulses so that scenarios can judge them afterwards
  always @(posedge mclk) begin
    if (queue_clear === 1'b1) qc_n++;
    if (protocol_reset === 1'b1) pr_n++;
    if (transfer_cancel === 1'b1) tc_n++;
  end
  always #20 mclk = ~mclk;
  nci_engine_model eng_u (.mclk, .resetn, .fire, .excess_event, .node_map);
  nci_cmd_interp dut_u (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .excess_event, .node_map, .line_rate, .own_node_id, .link_enable,
    .protocol_reset, .transfer_cancel, .retry_exp, .abort_on_excess, .tx_abort,
    .promisc_enable, .bcast_enable, .msg_filter, .queue_clear, .test_bad_crc,
    .test_ignore_token, .token_repeat, .tlt_value, .tip_value, .tac_value,
    .trp_value, .irq_suppress);
  // *****************************************
  // bus tasks
  // *****************************************
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk); reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge mclk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk); reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  task wait_done(input logic [7:0] c);
    int n;
    n = 0;
    rd(nci_pkg::REG_CMD);
    while (rd_v === nci_pkg::CMD_BUSY && n < 600) begin
      rd(nci_pkg::REG_CMD);
      n++;
    end
    `CHK("cmd readback", c, rd_v)
  endtask
  task cmd(input logic [7:0] c, input logic [7:0] p);
    wr(nci_pkg::REG_PARAM, p);
    wr(nci_pkg::REG_CMD, c);
    // no access at all during the link reset quiet time
    if (c == nci_pkg::CMD_LINK_RESET) begin
      repeat (nci_pkg::LINK_RESET_CYCLES + 8) @(posedge mclk);
    end
    wait_done(c);
  endtask
  task give_verdict;
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // *****************************************
  // scenarios
  // *****************************************
  task t_defaults;
    `CHK("retry_exp", 4'h7, retry_exp)
    `CHK("abort", 1'b0, abort_on_excess)
    `CHK("filter", 8'h3f, msg_filter)
    `CHK("tlt", 16'd1025, tlt_value)
    `CHK("timers", {16'd730, 16'd425, 16'd383}, {tip_value, tac_value, trp_value})
    `CHK("bcast", 1'b0, bcast_enable)
    `CHK("repeat", 1'b0, token_repeat)
  endtask
  task t_busy;
    @(posedge mclk); reg_addr <= 4'h1; reg_wdata <= 8'h42; reg_wr <= 1'b1;
    @(posedge mclk); reg_wr <= 1'b0; reg_rd <= 1'b1;
    @(posedge mclk); reg_rd <= 1'b0;
    #1 `CHK("busy read", 8'hff, reg_rdata)
    wait_done(8'h42);
    `CHK("bcast on", 1'b1, bcast_enable)
  endtask
  task t_rate_retry;
    cmd(8'h08, 8'h09);
    `CHK("rate", 4'h9, line_rate)
    `CHK("rate reset", 1, pr_n)
    cmd(8'h08, 8'h0a);
    `CHK("rate refused", {4'h9, 32'd1}, {line_rate, pr_n})
    cmd(8'h07, 8'h13);
    `CHK("retry", 5'h13, {abort_on_excess, retry_exp})
    wr(nci_pkg::REG_PARAM, nci_pkg::SUB_RATE);
    #1 `CHK("irq mask", 1'b1, irq_suppress)
    wr(nci_pkg::REG_CMD, 8'h29);
    #1 `CHK("irq unmask", 1'b0, irq_suppress)
    wr(nci_pkg::REG_PARAM, 8'h77);
    #1 `CHK("irq mask busy", 1'b1, irq_suppress)
    wait_done(8'h29);
    rd(nci_pkg::REG_PARAM);
    `CHK("setting", 8'h09, rd_v)
  endtask
  task t_excess;
    @(posedge mclk); fire <= 1'b1;
    @(posedge mclk); fire <= 1'b0;
    @(posedge mclk);
    #1 `CHK("tx_abort", 1'b1, tx_abort)
    rd(nci_pkg::REG_SYS_STATUS);
    `CHK("excess flag", 1'b1, rd_v[0])
    rd(nci_pkg::REG_SYS_STATUS);
    `CHK("flag cleared", 1'b0, rd_v[0])
  endtask
  task t_features;
    cmd(8'h10, 8'h34);
    cmd(8'h11, 8'h12);
    cmd(8'h16, 8'h78);
    `CHK("tlt set", 16'h1234, tlt_value)
    `CHK("trp set", 16'h0178, trp_value)
    cmd(8'h46, 8'h01);
    cmd(8'h46, 8'h02);
    cmd(8'h48, 8'h01);
    cmd(8'h4e, 8'h00);
    cmd(8'h0c, 8'h00);
    `CHK("tests", 2'h3, {test_bad_crc, test_ignore_token})
    `CHK("repeat on", 1'b1, token_repeat)
    `CHK("promisc on", 1'b1, promisc_enable)
    `CHK("filter set", 8'h00, msg_filter)
    cmd(8'h03, 8'h55);
    `CHK("unknown", 8'h00, msg_filter)
    cmd(8'h45, 8'h00);
    `CHK("queue clear", 1, qc_n)
    cmd(8'h4f, 8'h00);
    cmd(8'h43, 8'h00);
    `CHK("rx off", 2'h0, {promisc_enable, bcast_enable})
    cmd(8'h4d, 8'h01);
    rd(nci_pkg::REG_NODE_REPORT);
    `CHK("node walk", 8'h05, rd_v)
    cmd(8'h01, 8'h21);
    `CHK("own id", 8'h21, own_node_id)
    cmd(8'h38, 8'h00);
    `CHK("link on", 1'b1, link_enable)
    cmd(8'h37, 8'h00);
    `CHK("link off", {1'b0, 8'h00}, {link_enable, msg_filter})
    `CHK("cancels", 1, tc_n)
    cmd(8'h44, 8'h00);
    `CHK("after reset", {8'h3f, 4'h9, 1'b0}, {msg_filter, line_rate, link_enable})
    `CHK("reset clears", {8'h00, 2'h0}, {own_node_id, test_ignore_token, test_bad_crc})
    `CHK("reset pulses", {32'd2, 32'd2}, {pr_n, tc_n})
  endtask
  // *****************************************
  // sequence and timeout
  // *****************************************
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    #1 t_defaults();
    t_busy();
    t_rate_retry();
    t_excess();
    t_features();
    give_verdict();
  end
endmodule
